// >>> core/piw_ctrl.sv
// Vectored three level interrupt controller with standby wake logic
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
////////////////////////////////////////////////////////////////////////
// How it works
// - Each vector is ranked at one of three levels, top above high above low.
// - A request at or below the level in service is not offered.
// - Of several pending vectors, the highest level wins.
// - Among equal levels the smallest vector address wins.
// - Ten vectors from 0003h to 004Bh step eight bytes; two are unused.
// - Vectors one and two may be top or low, the rest high or low.
// - Vector three merges inputs c, e and timer-zero low half, vector nine the converter and both 8-bit timers, vector ten port zero.
// - Light standby halts the core only; clocks and peripherals run.
// - Light standby ends on the reset pin, a system reset or any interrupt.
// - Deep standby halts the core and peripherals and stops oscillators.
// - Deep standby ends on reset pin, system reset, inputs a, b, c, e or port zero.
// - Inputs a and b release deep standby only in a level mode.
// - Inputs a and b trigger on rise, fall, high or low, never both edges.
// - Inputs c, d and e trigger on rise, fall or both edges, never on level.
module piw_ctrl
   import piw_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt pins and on-chip events
   input wire logic [NEXT-1:0] ext_pin,
   input wire logic [6:0] periph_evt,
   input wire logic reset_pin_n,
   input wire logic sys_rst_evt,
   // Core side
   input wire logic core_ack,
   input wire logic core_ret,
   output piw_irq_t irq,
   output logic cpu_halt,
   output logic periph_stop,
   output logic osc_stop
);
   ////////////////////////////////////////////////////////////////////////
   logic [NVEC-1:0] lvl_sel;
   logic [9:0] ext_mode;
   logic [NSRC-1:0] src_en, pend, pend_set, pend_clr;
   logic [NEXT-1:0] pin_s1, pin_s2, pin_d;
   logic rp_s1, rp_s2;
   logic [2:0] isr;
   piw_lvl_t cur_lvl;
   piw_stby_t stby, next_stby;
   piw_bus_t ap;
   logic ap_act;
   logic [NVEC-1:0] vpend;
   piw_lvl_t vlvl [NVEC];
   piw_irq_t next_irq;
   logic [3:0] next_vidx;
   logic any_pend, deep_wake, light_wake, wr_stby;
   logic [NSRC-1:0] deep_mask;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // Bus: zero wait state, always OKAY; read data captured at address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap <= '0;
         ap_act <= 1'b0;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         ap_act <= hsel && htrans[1] && hready;
         ap <= '{wr: hwrite, addr: haddr};
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr)
         A_LVL: rd_mux[NVEC-1:0] = lvl_sel;
         A_MODE: rd_mux[9:0] = ext_mode;
         A_EN: rd_mux[NSRC-1:0] = src_en;
         A_PEND: rd_mux[NSRC-1:0] = pend;
         A_STAT: begin
            rd_mux[ST_ISR_LSB +: 3] = isr;
            rd_mux[ST_STBY_LSB +: 2] = stby;
            rd_mux[ST_LVL_LSB +: 2] = cur_lvl;
         end
         A_STBY: rd_mux[1:0] = stby;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl_sel <= LVL_RST;
         ext_mode <= MODE_RST;
         src_en <= EN_RST;
      end else if (ap_act && ap.wr) begin
         if (ap.addr == A_LVL) lvl_sel <= hwdata[NVEC-1:0];
         if (ap.addr == A_MODE) ext_mode <= hwdata[9:0];
         if (ap.addr == A_EN) src_en <= hwdata[NSRC-1:0];
      end
   end

   assign pend_clr = (ap_act && ap.wr && ap.addr == A_PEND) ?
      hwdata[NSRC-1:0] : '0;
   assign wr_stby = ap_act && ap.wr && ap.addr == A_STBY;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage and its delayed copy are looked at
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_d <= '0;
         rp_s1 <= 1'b1;
         rp_s2 <= 1'b1;
      end else begin
         pin_s1 <= ext_pin;
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
         rp_s1 <= reset_pin_n;
         rp_s2 <= rp_s1;
      end
   end

   // Trigger detection per external input
   always_comb begin
      logic [1:0] m;
      logic rise, fall;
      m = 2'h0;
      rise = 1'b0;
      fall = 1'b0;
      pend_set = '0;
      for (int i = 0; i < NEXT; i++) begin
         m = ext_mode[2*i +: 2];
         rise = pin_s2[i] && !pin_d[i];
         fall = !pin_s2[i] && pin_d[i];
         if (i < 2) begin
            unique case (m)
               TRG_RISE: pend_set[i] = rise;
               TRG_FALL: pend_set[i] = fall;
               TRG_HIGH: pend_set[i] = pin_s2[i];
               TRG_LOW: pend_set[i] = !pin_s2[i];
            endcase
         end else begin
            unique case (m)
               TRG_RISE: pend_set[i] = rise;
               TRG_FALL: pend_set[i] = fall;
               TRG_HIGH: pend_set[i] = rise || fall;
               TRG_LOW: pend_set[i] = 1'b0;
            endcase
         end
      end
      pend_set[NSRC-1:NEXT] = periph_evt;
   end

   // Pending flags: a new event wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= '0;
      end else begin
         pend <= (pend & ~pend_clr) | pend_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Merge sources into vectors and give each vector its level
   always_comb begin
      vpend = '0;
      for (int s = 0; s < NSRC; s++) begin
         if (pend[s] && src_en[s]) vpend[SRC_VEC[s]] = 1'b1;
      end
      for (int v = 0; v < NVEC; v++) begin
         if (!lvl_sel[v]) vlvl[v] = PIW_LOW;
         else if (TOP_VEC[v]) vlvl[v] = PIW_TOP;
         else vlvl[v] = PIW_HIGH;
      end
   end

   // Level in service is the highest nested one
   always_comb begin
      if (isr[2]) cur_lvl = PIW_TOP;
      else if (isr[1]) cur_lvl = PIW_HIGH;
      else if (isr[0]) cur_lvl = PIW_LOW;
      else cur_lvl = PIW_NONE;
   end

   // Arbiter: scan downward so the smallest index of the highest pending level survives
   always_comb begin
      next_irq = '0;
      next_vidx = 4'h0;
      for (int v = NVEC - 1; v >= 0; v--) begin
         if (vpend[v] && vlvl[v] > cur_lvl &&
             (!next_irq.valid || vlvl[v] >= next_irq.lvl)) begin
            next_irq.valid = 1'b1;
            next_irq.lvl = vlvl[v];
            next_vidx = 4'(v);
            next_irq.addr = VEC_BASE + (16'(v) << VEC_SHIFT);
         end
      end
   end

   // Offer to the core; cleared on the ack cycle to avoid a double take
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= '0;
      end else if (core_ack && irq.valid) begin
         irq <= '0;
      end else begin
         irq <= next_irq;
      end
   end

   // Nesting: ack sets the granted level, return drops the highest one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         isr <= 3'h0;
      end else begin
         logic [2:0] n;
         n = isr;
         if (core_ret) begin
            if (n[2]) n[2] = 1'b0;
            else if (n[1]) n[1] = 1'b0;
            else n[0] = 1'b0;
         end
         if (core_ack && irq.valid && irq.lvl != PIW_NONE) begin
            n[irq.lvl - 2'd1] = 1'b1;
         end
         isr <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Standby wake conditions
   assign any_pend = |(pend & src_en);
   assign deep_mask = DEEP_SRC | {10'h000,
      ext_mode[3], ext_mode[1]};
   assign deep_wake = |(pend & src_en & deep_mask);
   assign light_wake = !rp_s2 || sys_rst_evt;

   always_comb begin
      next_stby = stby;
      unique case (stby)
         STB_RUN: begin
            if (wr_stby && hwdata[1:0] == CMD_LIGHT) next_stby = STB_LIGHT;
            if (wr_stby && hwdata[1:0] == CMD_DEEP) next_stby = STB_DEEP;
         end
         STB_LIGHT: if (light_wake || any_pend) next_stby = STB_RUN;
         STB_DEEP: if (light_wake || deep_wake) next_stby = STB_RUN;
         default: next_stby = STB_RUN;
      endcase
   end

   // Standby state and its control outputs, kept in step
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stby <= STB_RUN;
         cpu_halt <= 1'b0;
         periph_stop <= 1'b0;
         osc_stop <= 1'b0;
      end else begin
         stby <= next_stby;
         cpu_halt <= next_stby != STB_RUN;
         periph_stop <= next_stby == STB_DEEP;
         osc_stop <= next_stby == STB_DEEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Helper terms for the checks
   logic hi_pend, lo_idx_pend;
   always_comb begin
      hi_pend = 1'b0;
      lo_idx_pend = 1'b0;
      for (int v = 0; v < NVEC; v++) begin
         if (vpend[v] && vlvl[v] > next_irq.lvl) hi_pend = 1'b1;
         if (vpend[v] && vlvl[v] == next_irq.lvl && 4'(v) < next_vidx)
            lo_idx_pend = 1'b1;
      end
   end

   chk_no_low_grant: assert property (@(posedge hclk) disable iff (!hresetn)
      next_irq.valid |-> next_irq.lvl > cur_lvl)
      else $error("offer not above level in service");
   chk_level_win: assert property (@(posedge hclk) disable iff (!hresetn)
      next_irq.valid |-> !hi_pend)
      else $error("higher level vector was passed over");
   chk_small_vector: assert property (@(posedge hclk) disable iff (!hresetn)
      next_irq.valid |-> !lo_idx_pend)
      else $error("smaller vector of equal level was passed over");
   chk_pair_levels: assert property (@(posedge hclk) disable iff (!hresetn)
      vlvl[0] inside {PIW_TOP, PIW_LOW} && vlvl[2] != PIW_TOP)
      else $error("vector level outside allowed pair");
   chk_ack_raises: assert property (@(posedge hclk) disable iff (!hresetn)
      core_ack && !core_ret && irq.valid |=> cur_lvl == $past(irq.lvl))
      else $error("grant did not raise level");
   chk_pend_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      pend_clr == '0 |=> (pend & $past(pend)) == $past(pend))
      else $error("pending flag lost without clear");
   chk_light_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      stby == STB_LIGHT && any_pend |=> stby == STB_RUN ##1 !cpu_halt)
      else $error("light standby not left on interrupt");
   chk_light_run: assert property (@(posedge hclk) disable iff (!hresetn)
      stby == STB_LIGHT |-> cpu_halt && !periph_stop && !osc_stop)
      else $error("light standby outputs wrong");
   chk_deep_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
      stby == STB_DEEP |-> cpu_halt && periph_stop && osc_stop)
      else $error("deep standby outputs wrong");
   chk_deep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      stby == STB_DEEP && deep_wake |=> stby == STB_RUN)
      else $error("deep standby not left on wake source");
   chk_edge_no_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      stby == STB_DEEP && !ext_mode[1] && light_wake == 1'b0 &&
      (pend & src_en & ~12'h001) == '0 |=> stby == STB_DEEP)
      else $error("edge mode input a woke deep standby");
endmodule
`default_nettype wire

// >>> core/piw_pkg.sv
// Shared constants and types of the priority interrupt and wake controller
`default_nettype none
package piw_pkg;
   localparam int NSRC = 12;
   localparam int NVEC = 10;
   localparam int NEXT = 5;
   // Register byte offsets
   localparam logic [7:0] A_LVL = 8'h00;
   localparam logic [7:0] A_MODE = 8'h04;
   localparam logic [7:0] A_EN = 8'h08;
   localparam logic [7:0] A_PEND = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_STBY = 8'h14;
   // Reset values
   localparam logic [NVEC-1:0] LVL_RST = 10'h000;
   localparam logic [9:0] MODE_RST = 10'h000;
   localparam logic [NSRC-1:0] EN_RST = 12'h000;
   // Status field positions
   localparam int ST_ISR_LSB = 0;
   localparam int ST_STBY_LSB = 4;
   localparam int ST_LVL_LSB = 8;
   // Trigger codes; HIGH means both edges on inputs c to e
   localparam logic [1:0] TRG_RISE = 2'h0;
   localparam logic [1:0] TRG_FALL = 2'h1;
   localparam logic [1:0] TRG_HIGH = 2'h2;
   localparam logic [1:0] TRG_LOW = 2'h3;
   // Standby commands
   localparam logic [1:0] CMD_LIGHT = 2'h1;
   localparam logic [1:0] CMD_DEEP = 2'h2;
   // Vector addresses
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam int VEC_SHIFT = 3;
   // Vectors whose upper level is the top level
   localparam logic [NVEC-1:0] TOP_VEC = 10'h003;
   // Sources that always release deep standby (c, e, port zero)
   localparam logic [NSRC-1:0] DEEP_SRC = 12'h814;
   // Source to vector: a,b,c,d,e,t0l,t0h,serial,conv,timer a,timer b,port0
   localparam logic [3:0] SRC_VEC [NSRC] = '{4'h0, 4'h1, 4'h2, 4'h3,
      4'h2, 4'h2, 4'h4, 4'h7, 4'h8, 4'h8, 4'h8, 4'h9};
   typedef enum logic [1:0] {
      PIW_NONE = 2'b00, PIW_LOW = 2'b01, PIW_HIGH = 2'b10, PIW_TOP = 2'b11
   } piw_lvl_t;
   typedef enum logic [1:0] {
      STB_RUN = 2'b00, STB_LIGHT = 2'b01, STB_DEEP = 2'b10
   } piw_stby_t;
   typedef struct packed {
      logic valid;
      piw_lvl_t lvl;
      logic [15:0] addr;
   } piw_irq_t;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
   } piw_bus_t;
endpackage
`default_nettype wire

// >>> sim/piw_core_model.sv
// Model of the CPU core sequencer that takes vectored offers
`default_nettype none
module piw_core_model
   import piw_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Offer and halt from the controller
   input wire piw_irq_t irq,
   input wire logic cpu_halt,
   // Bench controls
   input wire logic take_en,
   input wire logic ret_req,
   // Core answers and grant log
   output logic core_ack,
   output logic core_ret,
   output logic [15:0] gaddr,
   output piw_lvl_t glvl,
   output logic [7:0] gcnt
);
   ////////////////////////////////////////////////////////////////////////
   // A halted core cannot take an offer; ack is a one-cycle pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_ack <= 1'b0;
         core_ret <= 1'b0;
      end else begin
         core_ack <= take_en & irq.valid & ~core_ack & ~cpu_halt;
         core_ret <= ret_req;
      end
   end
   // Log what was handed over at the taking edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gaddr <= 16'h0000;
         glvl <= PIW_NONE;
         gcnt <= 8'h00;
      end else if (core_ack & irq.valid) begin
         gaddr <= irq.addr;
         glvl <= irq.lvl;
         gcnt <= gcnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> sim/piw_ctrl_tb.sv
// Self-checking bench for the interrupt and wake controller
`default_nettype none
module piw_ctrl_tb
   import piw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, reset_pin_n;
   logic sys_rst_evt, core_ack, core_ret, cpu_halt, periph_stop, osc_stop;
   logic take_en, ret_req;
   logic [7:0] haddr, gcnt, seen;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [NEXT-1:0] ext_pin;
   logic [6:0] periph_evt;
   logic [15:0] gaddr;
   piw_lvl_t glvl;
   piw_irq_t irq;
   int error_cnt = 0;
   int checks = 0;
   ////////////////////////////////////////////////////////////////////////
   // Bus ready loops back, as with a single slave
   piw_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ext_pin(ext_pin),
      .periph_evt(periph_evt), .reset_pin_n(reset_pin_n),
      .sys_rst_evt(sys_rst_evt), .core_ack(core_ack), .core_ret(core_ret),
      .irq(irq), .cpu_halt(cpu_halt), .periph_stop(periph_stop),
      .osc_stop(osc_stop));
   piw_core_model core_u (.hclk(hclk), .hresetn(hresetn), .irq(irq),
      .cpu_halt(cpu_halt), .take_en(take_en), .ret_req(ret_req),
      .core_ack(core_ack), .core_ret(core_ret), .gaddr(gaddr),
      .glvl(glvl), .gcnt(gcnt));
   // Clock at 25 MHz
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One AHB single transfer; waits on ready, using a cycle count only as a time limit
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0000_0000, x);
      chk("register read", e, x);
      chk("bus response", 32'h0, {31'h0, hresp});
   endtask
   // Event pulse, with a quiet cycle so pulses never merge
   task automatic evt(input logic [6:0] m);
      periph_evt <= m;
      @(posedge hclk);
      periph_evt <= 7'h00;
      @(posedge hclk);
   endtask
   task automatic ret();
      ret_req <= 1'b1;
      @(posedge hclk);
      ret_req <= 1'b0;
   endtask
   // Handler end: clear the pending flag, then return
   task automatic done(input logic [11:0] b);
      wr(A_PEND, {20'h00000, b});
      ret();
   endtask
   task automatic grant(input logic [15:0] ea, input piw_lvl_t el);
      int n;
      n = 0;
      while (gcnt === seen && n < 300) begin
         @(posedge hclk);
         n++;
      end
      seen = gcnt;
      chk("grant address", {16'h0000, ea}, {16'h0000, gaddr});
      chk("grant level", {30'h0, el}, {30'h0, glvl});
   endtask
   task automatic none();
      repeat (12) @(posedge hclk);
      chk("grant count", {24'h0, seen}, {24'h0, gcnt});
   endtask
   task automatic stby(input logic [1:0] cmd);
      logic d;
      d = (cmd == CMD_DEEP);
      wr(A_STBY, {30'h0, cmd});
      repeat (2) @(posedge hclk);
      chk("halt and stops", {29'h0, 1'b1, d, d},
         {29'h0, cpu_halt, periph_stop, osc_stop});
   endtask
   task automatic woke();
      int n;
      n = 0;
      while (cpu_halt !== 1'b0 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      chk("cpu halt", 32'h0, {31'h0, cpu_halt});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, sys_rst_evt, ret_req} = 4'h0;
      {haddr, seen, periph_evt, ext_pin} = '0;
      {htrans, hwdata} = '0;
      hsize = 3'h2;
      reset_pin_n = 1'b1;
      take_en = 1'b1;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      // Reset values, read-only status, unmapped hole
      rdc(A_LVL, 32'h0);
      rdc(A_MODE, 32'h0);
      rdc(A_EN, 32'h0);
      wr(A_STAT, 32'hFFFF_FFFF);
      rdc(A_STAT, 32'h0);
      rdc(8'h18, 32'h0);
      wr(A_LVL, 32'h0000_0101);
      wr(A_EN, 32'h0000_0FFF);
      rdc(A_LVL, 32'h0000_0101);
      // Low serial service, then a high request nests over it
      evt(7'h04);
      grant(16'h003B, PIW_LOW);
      rdc(A_PEND, 32'h0000_0080);
      rdc(A_STAT, 32'h0000_0101);
      wr(A_PEND, 32'h0000_0080);
      evt(7'h12);
      grant(16'h0043, PIW_HIGH);
      rdc(A_STAT, 32'h0000_0203);
      wr(A_PEND, 32'h0000_0200);
      ret();
      none();
      ret();
      grant(16'h0023, PIW_LOW);
      done(12'h040);
      // Slow core: two low requests wait, smallest vector goes first
      take_en <= 1'b0;
      evt(7'h40);
      evt(7'h01);
      take_en <= 1'b1;
      grant(16'h0013, PIW_LOW);
      done(12'h020);
      grant(16'h004B, PIW_LOW);
      done(12'h800);
      // Input a at top level; input c on both edges
      ext_pin[0] <= 1'b1;
      grant(16'h0003, PIW_TOP);
      done(12'h001);
      wr(A_MODE, 32'h0000_0020);
      ext_pin[2] <= 1'b1;
      grant(16'h0013, PIW_LOW);
      done(12'h004);
      ext_pin[2] <= 1'b0;
      grant(16'h0013, PIW_LOW);
      done(12'h004);
      ext_pin[0] <= 1'b0;
      // Light standby left by the reset pin
      stby(CMD_LIGHT);
      rdc(A_STBY, 32'h1);
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge hclk);
      reset_pin_n <= 1'b1;
      woke();
      // Light standby left by an ordinary interrupt
      stby(CMD_LIGHT);
      evt(7'h04);
      woke();
      grant(16'h003B, PIW_LOW);
      done(12'h080);
      // Deep standby: edge-mode input a stays asleep, port zero wakes
      stby(CMD_DEEP);
      ext_pin[0] <= 1'b1;
      repeat (10) @(posedge hclk);
      chk("cpu halt", 32'h1, {31'h0, cpu_halt});
      evt(7'h40);
      woke();
      grant(16'h0003, PIW_TOP);
      done(12'h001);
      grant(16'h004B, PIW_LOW);
      done(12'h800);
      // Deep standby: level-mode input a wakes, then a system reset
      ext_pin[0] <= 1'b0;
      wr(A_MODE, 32'h0000_0022);
      stby(CMD_DEEP);
      ext_pin[0] <= 1'b1;
      woke();
      grant(16'h0003, PIW_TOP);
      ext_pin[0] <= 1'b0;
      repeat (6) @(posedge hclk);
      done(12'h001);
      stby(CMD_DEEP);
      sys_rst_evt <= 1'b1;
      @(posedge hclk);
      sys_rst_evt <= 1'b0;
      woke();
      report_and_stop();
   end
endmodule
`default_nettype wire
